// *** rtl/lpt_pkg.sv ***
// shared constants and types for the local bus interrupt pass-through and dma kick block
package lpt_pkg;

  // register byte offsets
  localparam logic [7:0] LPT_OFS_GLOBAL_CFG  = 8'h00;
  localparam logic [7:0] LPT_OFS_LOCAL_CFG   = 8'h40;
  localparam logic [7:0] LPT_OFS_LOCAL_STAT  = 8'h44;
  localparam logic [7:0] LPT_OFS_START_XFER  = 8'h48;
  localparam logic [7:0] LPT_OFS_PERIPH_IQBA = 8'h4c;
  localparam logic [7:0] LPT_OFS_TX_IQBA     = 8'h50;
  localparam logic [7:0] LPT_OFS_RX_IQBA     = 8'h54;

  // fixed pass-through vector value
  localparam logic [31:0] LPT_PASS_VECTOR    = 32'h86000000;
  // dma vector code: bit 1 set for transmit, bit 0 set for channel b
  localparam logic [31:0] LPT_DMA_VEC_CODE   = 32'h00000000;
  localparam int          LPT_DMA_DIR_BIT    = 1;
  localparam int          LPT_DMA_CHAN_BIT   = 0;

  // reset values and writable masks
  localparam logic [31:0] LPT_LOCAL_CFG_RST  = 32'h00000000;
  localparam logic [31:0] LPT_LOCAL_CFG_MASK = 32'h0000ffff;
  localparam logic [31:0] LPT_GLOBAL_CFG_RST = 32'h00000000;
  localparam logic [31:0] LPT_GLOBAL_CFG_MSK = 32'h000000f1;
  localparam logic [31:0] LPT_START_XFER_RST = 32'h00000003;
  localparam logic [31:0] LPT_START_XFER_MSK = 32'h00000003;
  localparam logic [31:0] LPT_QUEUE_BASE_RST = 32'h00000000;
  localparam logic [31:0] LPT_ZERO_WORD      = 32'h00000000;

  // channel indices into the dma event and line vectors
  localparam int LPT_CH_A = 0;
  localparam int LPT_CH_B = 1;

  typedef struct packed {
    logic [15:0] reserved;
    logic [2:0]  misc_three_bit_field;
    logic        combined_ack_pins;
    logic        shared_dma_direction;     // 1: shared lines serve transmit
    logic        shared_dma_lines;
    logic        aux_irq_setting;
    logic        state_machine_reset_n;
    logic        ext_bus_ctrl_reset_n;
    logic        chan_b_transfer_mode;
    logic        chan_a_transfer_mode;
    logic        chan_b_disregard_irq;
    logic        chan_a_disregard_irq;
    logic        separate_irq_pins_enable;
    logic        irq_two_polarity;         // 1: active low
    logic        irq_one_polarity;         // 1: active low
  } lpt_local_cfg_t;

  typedef struct packed {
    logic [23:0] reserved;
    logic [3:0]  local_bus_clock_divider;
    logic [2:0]  reserved_lo;
    logic        dma_assist_mode_select;
  } lpt_global_cfg_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } lpt_vec_t;

  typedef enum logic [2:0] {
    LPT_ST_IDLE = 3'h1,
    LPT_ST_PASS = 3'h2,
    LPT_ST_DMA  = 3'h4
  } lpt_state_t;

  typedef struct packed {
    lpt_state_t      state;
    lpt_local_cfg_t  local_cfg;
    lpt_global_cfg_t global_cfg;
    logic [1:0]      kick_field;
    logic [31:0]     periph_iqba;
    logic [31:0]     tx_iqba;
    logic [31:0]     rx_iqba;
    logic [1:0]      irq_sync1;
    logic [1:0]      irq_sync2;
    logic [1:0]      irq_act_prev;
    logic            pass_pend;
    logic [1:0]      dma_tx_pend;
    logic [1:0]      dma_rx_pend;
    logic            dma_sel_tx;
    logic            dma_sel_b;
    logic [31:0]     rdata;
    logic            rvalid;
    lpt_vec_t        vec;
    logic            vec_valid;
    logic [1:0]      kick_pulse;
    logic [3:0]      dma_line_en;
  } lpt_state_all_t;

endpackage : lpt_pkg

// *** rtl/lpt_irq_pass.sv ***
// local bus interrupt pass-through, dma kick and queue vector writer
`timescale 1ns/1ps
module lpt_irq_pass
  import lpt_pkg::*;
(
  input  wire logic        clk_sys,                  // 40 mhz device clock
  input  wire logic        rst,                      // synchronous reset, active high
  input  wire logic        reg_wr,                   // register write strobe
  input  wire logic        reg_rd,                   // register read strobe
  input  wire logic [7:0]  reg_addr,                 // register byte address
  input  wire logic [31:0] reg_wdata,                // register write data
  output logic      [31:0] reg_rdata,                // read data, one cycle after reg_rd
  output logic             reg_rvalid,               // read data valid pulse
  input  wire logic        periph_irq_in_one,        // peripheral interrupt line one
  input  wire logic        periph_irq_in_two,        // peripheral interrupt line two
  input  wire logic [1:0]  dma_evt_tx,               // dma transmit event pulse per channel
  input  wire logic [1:0]  dma_evt_rx,               // dma receive event pulse per channel
  output logic             vec_valid,                // vector write request
  input  wire logic        vec_ready,                // vector write accepted
  output logic      [31:0] vec_addr,                 // queue address of vector
  output logic      [31:0] vec_data,                 // vector value
  output logic      [1:0]  kick_chan,                // descriptor fetch kick pulse, a and b
  output logic      [3:0]  dma_line_en,              // a rx, a tx, b rx, b tx line enables
  output logic             ext_bus_ctrl_enable,      // external bus controller run
  output logic      [3:0]  local_bus_clock_divider   // local bus clock division
);

  lpt_state_all_t st_q;
  lpt_state_all_t st_d;

  // irq level to asserted, honouring polarity
  function automatic logic irq_active(input logic lvl, input logic pol);
    return lvl ^ pol;
  endfunction : irq_active

  // within one direction channel a is served before channel b
  function automatic logic pick_chan_b(input logic [1:0] pend);
    return !pend[LPT_CH_A];
  endfunction : pick_chan_b

  // address plus data of a dma vector for one direction and channel
  function automatic lpt_vec_t dma_vector(input logic tx, input logic chb,
                                          input logic [31:0] tx_base,
                                          input logic [31:0] rx_base);
    lpt_vec_t v;
    v.addr = tx ? tx_base : rx_base;
    v.data = LPT_DMA_VEC_CODE;
    v.data[LPT_DMA_DIR_BIT]  = tx;
    v.data[LPT_DMA_CHAN_BIT] = chb;
    return v;
  endfunction : dma_vector

  // reset image; the soft hold of the state machine reuses it
  localparam lpt_state_all_t ST_RESET = '{
    state:        LPT_ST_IDLE,
    local_cfg:    lpt_local_cfg_t'(LPT_LOCAL_CFG_RST),
    global_cfg:   lpt_global_cfg_t'(LPT_GLOBAL_CFG_RST),
    kick_field:   LPT_START_XFER_RST[1:0],
    periph_iqba:  LPT_QUEUE_BASE_RST,
    tx_iqba:      LPT_QUEUE_BASE_RST,
    rx_iqba:      LPT_QUEUE_BASE_RST,
    irq_sync1:    2'h0,
    irq_sync2:    2'h0,
    irq_act_prev: 2'h0,
    pass_pend:    1'h0,
    dma_tx_pend:  2'h0,
    dma_rx_pend:  2'h0,
    dma_sel_tx:   1'h0,
    dma_sel_b:    1'h0,
    rdata:        LPT_ZERO_WORD,
    rvalid:       1'h0,
    vec:          '0,
    vec_valid:    1'h0,
    kick_pulse:   2'h0,
    dma_line_en:  4'h0
  };

  always_comb begin
    logic [1:0]  act;
    logic [1:0]  rise;
    logic        fsm_run;
    logic        pass_clr;
    logic [1:0]  tx_clr;
    logic [1:0]  rx_clr;
    logic        pass_set;
    logic [31:0] wval;
    logic [1:0]  tx_set;
    logic [1:0]  rx_set;
    logic        fsm_next;
    act      = 2'h0;
    rise     = 2'h0;
    fsm_run  = 1'b0;
    pass_clr = 1'b0;
    tx_clr   = 2'h0;
    rx_clr   = 2'h0;
    pass_set = 1'b0;
    wval     = LPT_ZERO_WORD;
    tx_set   = 2'h0;
    rx_set   = 2'h0;
    fsm_next = 1'b0;
    st_d     = st_q;

    // two flops before anything looks at the pins
    st_d.irq_sync1 = {periph_irq_in_two, periph_irq_in_one};
    st_d.irq_sync2 = st_q.irq_sync1;

    act[0] = irq_active(st_q.irq_sync2[0], st_q.local_cfg.irq_one_polarity);
    act[1] = irq_active(st_q.irq_sync2[1], st_q.local_cfg.irq_two_polarity);
    act[1] = act[1] & st_q.local_cfg.separate_irq_pins_enable;
    // edge detector starts inactive, matching idle pins after reset
    st_d.irq_act_prev = act;
    rise = act & ~st_q.irq_act_prev;

    // channel a irq is only swallowed when its packet path owns it
    if (!st_q.local_cfg.chan_a_disregard_irq && st_q.local_cfg.chan_a_transfer_mode) begin
      rise[0] = 1'b0;
    end
    if (!st_q.local_cfg.chan_b_disregard_irq && st_q.local_cfg.chan_b_transfer_mode) begin
      rise[1] = 1'b0;
    end

    fsm_run  = st_q.local_cfg.state_machine_reset_n;
    pass_set = fsm_run & (|rise);

    // dma events are taken only while the state machine runs
    tx_set   = dma_evt_tx & {2{fsm_run}};
    rx_set   = dma_evt_rx & {2{fsm_run}};

    // default register outputs
    st_d.rvalid     = 1'b0;
    st_d.kick_pulse = 2'h0;

    // vector writer
    case (st_q.state)
      LPT_ST_IDLE: begin
        if (st_q.pass_pend) begin
          st_d.vec.addr  = st_q.periph_iqba;
          st_d.vec.data  = LPT_PASS_VECTOR;
          st_d.vec_valid = 1'b1;
          st_d.state     = LPT_ST_PASS;
        end else if (|(st_q.dma_tx_pend | st_q.dma_rx_pend)) begin
          st_d.dma_sel_tx = |st_q.dma_tx_pend;
          st_d.dma_sel_b  = (|st_q.dma_tx_pend) ? pick_chan_b(st_q.dma_tx_pend)
                                                : pick_chan_b(st_q.dma_rx_pend);
          st_d.vec        = dma_vector(st_d.dma_sel_tx, st_d.dma_sel_b,
                                       st_q.tx_iqba, st_q.rx_iqba);
          st_d.vec_valid  = 1'b1;
          st_d.state      = LPT_ST_DMA;
        end
      end
      LPT_ST_PASS: begin
        // events during the wait fold into this vector
        if (vec_ready) begin
          pass_clr       = 1'b1;
          st_d.vec_valid = 1'b0;
          st_d.state     = LPT_ST_IDLE;
        end
      end
      LPT_ST_DMA: begin
        // only the stream served is retired; the rest wait their turn
        if (vec_ready) begin
          if (st_q.dma_sel_tx) begin
            tx_clr[st_q.dma_sel_b] = 1'b1;
          end else begin
            rx_clr[st_q.dma_sel_b] = 1'b1;
          end
          st_d.vec_valid = 1'b0;
          st_d.state     = LPT_ST_IDLE;
        end
      end
      default: begin
        st_d.vec_valid = 1'b0;
        st_d.state     = LPT_ST_IDLE;
      end
    endcase

    // a new event in the clearing cycle survives
    st_d.pass_pend   = (st_q.pass_pend & ~pass_clr) | pass_set;
    st_d.dma_tx_pend = (st_q.dma_tx_pend & ~tx_clr) | tx_set;
    st_d.dma_rx_pend = (st_q.dma_rx_pend & ~rx_clr) | rx_set;

    // register writes
    if (reg_wr) begin
      if (reg_addr == LPT_OFS_LOCAL_CFG) begin
        st_d.local_cfg = lpt_local_cfg_t'(reg_wdata & LPT_LOCAL_CFG_MASK);
      end else if (reg_addr == LPT_OFS_GLOBAL_CFG) begin
        st_d.global_cfg = lpt_global_cfg_t'(reg_wdata & LPT_GLOBAL_CFG_MSK);
      end else if (reg_addr == LPT_OFS_START_XFER) begin
        wval            = reg_wdata & LPT_START_XFER_MSK;
        st_d.kick_field = wval[1:0];
        // a zero written to a go field restarts that channel
        st_d.kick_pulse = ~wval[1:0] & {2{fsm_run}};
      end else if (reg_addr == LPT_OFS_PERIPH_IQBA) begin
        st_d.periph_iqba = reg_wdata;
      end else if (reg_addr == LPT_OFS_TX_IQBA) begin
        st_d.tx_iqba = reg_wdata;
      end else if (reg_addr == LPT_OFS_RX_IQBA) begin
        st_d.rx_iqba = reg_wdata;
      end
    end

    // register reads; unmapped addresses read zero
    if (reg_rd) begin
      st_d.rvalid = 1'b1;
      if (reg_addr == LPT_OFS_LOCAL_CFG) begin
        st_d.rdata = st_q.local_cfg;
      end else if (reg_addr == LPT_OFS_GLOBAL_CFG) begin
        st_d.rdata = st_q.global_cfg;
      end else if (reg_addr == LPT_OFS_LOCAL_STAT) begin
        // raw pin levels, independent of polarity and enables
        st_d.rdata = {30'h0, st_q.irq_sync2};
      end else if (reg_addr == LPT_OFS_START_XFER) begin
        st_d.rdata = {30'h0, st_q.kick_field};
      end else if (reg_addr == LPT_OFS_PERIPH_IQBA) begin
        st_d.rdata = st_q.periph_iqba;
      end else if (reg_addr == LPT_OFS_TX_IQBA) begin
        st_d.rdata = st_q.tx_iqba;
      end else if (reg_addr == LPT_OFS_RX_IQBA) begin
        st_d.rdata = st_q.rx_iqba;
      end else begin
        st_d.rdata = LPT_ZERO_WORD;
      end
    end

    // dma line enables: a rx, a tx, b rx, b tx
    st_d.dma_line_en = 4'h0;
    if (fsm_run && st_q.global_cfg.dma_assist_mode_select) begin
      if (st_q.local_cfg.chan_a_transfer_mode) begin
        if (st_q.local_cfg.shared_dma_lines) begin
          st_d.dma_line_en[1] = st_q.local_cfg.shared_dma_direction;
          st_d.dma_line_en[0] = !st_q.local_cfg.shared_dma_direction;
        end else begin
          st_d.dma_line_en[1:0] = 2'h3;
        end
      end
      // channel b has no shared-lines option
      if (st_q.local_cfg.chan_b_transfer_mode) begin
        st_d.dma_line_en[3:2] = 2'h3;
      end
    end

    // state machine held as after hardware reset; registers keep values.
    // the hold follows the bit as written, so a vector in flight is
    // withdrawn at once; a sink must not count a vector it never accepted
    fsm_next = st_d.local_cfg.state_machine_reset_n;
    if (!fsm_next) begin
      st_d.state        = ST_RESET.state;
      st_d.pass_pend    = ST_RESET.pass_pend;
      st_d.dma_tx_pend  = ST_RESET.dma_tx_pend;
      st_d.dma_rx_pend  = ST_RESET.dma_rx_pend;
      st_d.vec_valid    = ST_RESET.vec_valid;
      st_d.dma_sel_tx   = ST_RESET.dma_sel_tx;
      st_d.dma_sel_b    = ST_RESET.dma_sel_b;
      st_d.kick_pulse   = ST_RESET.kick_pulse;
      st_d.dma_line_en  = ST_RESET.dma_line_en;
    end
  end

  // one register stage for all state; the outputs tap it directly
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // status and config outputs mirror their register bits
  assign reg_rdata               = st_q.rdata;
  assign reg_rvalid              = st_q.rvalid;
  assign vec_valid               = st_q.vec_valid;
  assign vec_addr                = st_q.vec.addr;
  assign vec_data                = st_q.vec.data;
  assign kick_chan               = st_q.kick_pulse;
  assign dma_line_en             = st_q.dma_line_en;
  assign ext_bus_ctrl_enable     = st_q.local_cfg.ext_bus_ctrl_reset_n;
  assign local_bus_clock_divider = st_q.global_cfg.local_bus_clock_divider;

endmodule : lpt_irq_pass

// *** testbench/lpt_irq_pass_checker.sv ***
// port assertions for the pass-through block
`timescale 1ns/1ps
module lpt_irq_pass_checker
  import lpt_pkg::*;
(
  input wire logic        clk_sys,            // clock
  input wire logic        rst,                // reset
  input wire logic        reg_wr,             // write strobe
  input wire logic        reg_rd,             // read strobe
  input wire logic [7:0]  reg_addr,           // address
  input wire logic [31:0] reg_wdata,          // write data
  input wire logic [31:0] reg_rdata,          // read data
  input wire logic        periph_irq_in_one,  // line one
  input wire logic        periph_irq_in_two,  // line two
  input wire logic        vec_valid,          // vector request
  input wire logic        vec_ready,          // vector accept
  input wire logic [31:0] vec_addr,           // vector address
  input wire logic [31:0] vec_data,           // vector value
  input wire logic [1:0]  kick_chan,          // kicks
  input wire logic        ext_bus_ctrl_enable // bus ctrl run
);
  logic        sm_on_q;
  logic [31:0] pbase_q;
  logic [31:0] tbase_q;
  logic [31:0] rbase_q;
  // shadow of the few config fields the vector checks need
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sm_on_q <= 1'b0;
      pbase_q <= LPT_QUEUE_BASE_RST;
      tbase_q <= LPT_QUEUE_BASE_RST;
      rbase_q <= LPT_QUEUE_BASE_RST;
    end else if (reg_wr) begin
      if (reg_addr == LPT_OFS_LOCAL_CFG) sm_on_q <= reg_wdata[8];
      if (reg_addr == LPT_OFS_PERIPH_IQBA) pbase_q <= reg_wdata;
      if (reg_addr == LPT_OFS_TX_IQBA) tbase_q <= reg_wdata;
      if (reg_addr == LPT_OFS_RX_IQBA) rbase_q <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_VEC_HOLD: assert property (vec_valid && !vec_ready |=>
    (vec_valid && $stable(vec_addr) && $stable(vec_data)) || !sm_on_q)
    else $error("vector not held");
  AST_VEC_GAP: assert property (vec_valid && vec_ready |=> !vec_valid)
    else $error("no idle cycle after accept");
  AST_VEC_VALUE: assert property (vec_valid |->
    vec_data == LPT_PASS_VECTOR || vec_data[31:2] == 30'h0) else $error("bad vector value");
  AST_PASS_ADDR: assert property (vec_valid && vec_data == LPT_PASS_VECTOR |->
    vec_addr == pbase_q) else $error("pass vector address wrong");
  AST_DMA_ADDR: assert property (vec_valid && vec_data != LPT_PASS_VECTOR |->
    vec_addr == (vec_data[LPT_DMA_DIR_BIT] ? tbase_q : rbase_q)) else $error("dma address wrong");
  AST_SM_HELD: assert property (!sm_on_q |-> !vec_valid)
    else $error("vector while machine held");
  AST_KICK: assert property (reg_wr && reg_addr == LPT_OFS_START_XFER && sm_on_q |=>
    kick_chan == ~$past(reg_wdata[1:0])) else $error("kick mismatch");
  AST_NO_POLL: assert property (kick_chan != 2'b00 |-> $past(reg_wr) &&
    $past(reg_addr) == LPT_OFS_START_XFER && $past(sm_on_q)) else $error("unasked kick");
  AST_EBC: assert property (reg_wr && reg_addr == LPT_OFS_LOCAL_CFG |=>
    ext_bus_ctrl_enable == $past(reg_wdata[7])) else $error("bus ctrl run wrong");
  AST_STAT: assert property (reg_rd && reg_addr == LPT_OFS_LOCAL_STAT |=>
    reg_rdata == {30'h0, $past(periph_irq_in_two, 3), $past(periph_irq_in_one, 3)})
    else $error("status levels wrong");
  COV_PASS: cover property (vec_valid && vec_ready && vec_data == LPT_PASS_VECTOR);
  COV_DMA: cover property (vec_valid && vec_ready && vec_data != LPT_PASS_VECTOR);
  COV_KICK: cover property (kick_chan != 2'b00);
endmodule : lpt_irq_pass_checker

// *** testbench/lpt_periph_model.sv ***
// peripheral side model: interrupt lines and vector sink
`timescale 1ns/1ps
module lpt_periph_model (
  input  wire logic        clk_sys,   // clock
  input  wire logic [1:0]  irq_lvl,   // wanted line levels
  input  wire logic        stall,     // hold off accepts
  input  wire logic        vec_valid, // vector request
  input  wire logic [31:0] vec_addr,  // vector address
  input  wire logic [31:0] vec_data,  // vector value
  output logic             irq_one,   // line one
  output logic             irq_two,   // line two
  output logic             vec_ready, // accept
  output logic [7:0]       acc_cnt,   // vectors taken
  output logic [31:0]      acc_addr,  // last address
  output logic [31:0]      acc_data   // last value
);
  initial begin
    {irq_one, irq_two, vec_ready} = 3'h0;
    {acc_cnt, acc_addr, acc_data} = 72'h0;
  end
  // line and accept outputs move just after the edge, like a real driver
  always @(posedge clk_sys) begin
    if (vec_valid && vec_ready) begin
      acc_cnt <= acc_cnt + 8'h01;
      acc_addr <= vec_addr;
      acc_data <= vec_data;
    end
    irq_one <= #1 irq_lvl[0];
    irq_two <= #1 irq_lvl[1];
    vec_ready <= #1 !stall;
  end
endmodule : lpt_periph_model

// *** testbench/test_lpt_irq_pass.sv ***
// self-checking bench for the pass-through block
`timescale 1ns/1ps
module test_lpt_irq_pass;
  import lpt_pkg::*;
  localparam logic [31:0] PB = 32'h00001000;
  localparam logic [31:0] TB = 32'h00002000;
  localparam logic [31:0] RB = 32'h00003000;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        stall = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [1:0]  irq_lvl = 2'h0;
  logic [1:0]  dma_evt_tx = 2'h0;
  logic [1:0]  dma_evt_rx = 2'h0;
  logic [31:0] reg_rdata, vec_addr, vec_data, acc_addr, acc_data;
  logic        reg_rvalid, vec_valid, vec_ready, irq_one, irq_two, ebc_en;
  logic [1:0]  kick_chan;
  logic [3:0]  dma_line_en, clk_div;
  logic [7:0]  acc_cnt;
  int          error_cnt = 0;
  int          checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  lpt_irq_pass i_dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .periph_irq_in_one(irq_one), .periph_irq_in_two(irq_two),
    .dma_evt_tx(dma_evt_tx), .dma_evt_rx(dma_evt_rx), .vec_valid(vec_valid),
    .vec_ready(vec_ready), .vec_addr(vec_addr), .vec_data(vec_data), .kick_chan(kick_chan),
    .dma_line_en(dma_line_en), .ext_bus_ctrl_enable(ebc_en), .local_bus_clock_divider(clk_div));
  lpt_periph_model i_periph (.clk_sys(clk_sys), .irq_lvl(irq_lvl), .stall(stall),
    .vec_valid(vec_valid), .vec_addr(vec_addr), .vec_data(vec_data), .irq_one(irq_one),
    .irq_two(irq_two), .vec_ready(vec_ready), .acc_cnt(acc_cnt), .acc_addr(acc_addr),
    .acc_data(acc_data));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    idle(1);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys) #1;
    reg_rd = 1'b1;
    reg_addr = a;
    idle(1);
    reg_rd = 1'b0;
    chk("read valid", 32'h1, reg_rvalid);
    chk("read data", exp, reg_rdata);
  endtask : rd
  // fixed settle covers sync, pending and one accept with margin
  task automatic pins(input logic [1:0] l, input logic [7:0] n);
    irq_lvl = l;
    idle(12);
    chk("vector count", n, acc_cnt);
  endtask : pins
  task automatic expect_vec(input logic [7:0] n, input logic [31:0] a, input logic [31:0] d);
    for (int i = 0; i < 40 && acc_cnt !== n; i++) idle(1);
    chk("vector count", n, acc_cnt);
    if (acc_cnt !== n) final_report();
    chk("vector address", a, acc_addr);
    chk("vector value", d, acc_data);
  endtask : expect_vec
  initial begin
    idle(2);
    rst = 1'b0;
    rd(LPT_OFS_START_XFER, LPT_START_XFER_RST);
    rd(LPT_OFS_LOCAL_CFG, LPT_LOCAL_CFG_RST);
    rd(8'h80, LPT_ZERO_WORD);
    wr(LPT_OFS_PERIPH_IQBA, PB);
    wr(LPT_OFS_TX_IQBA, TB);
    wr(LPT_OFS_RX_IQBA, RB);
    wr(LPT_OFS_GLOBAL_CFG, 32'h00000030);
    chk("clock divider", 32'h3, clk_div);
    wr(LPT_OFS_LOCAL_CFG, 32'h00000098);
    chk("bus ctrl run", 32'h1, ebc_en);
    pins(2'b01, 8'h00);
    pins(2'b00, 8'h00);
    wr(LPT_OFS_LOCAL_CFG, 32'h00000198);
    pins(2'b01, 8'h01);
    expect_vec(8'h01, PB, LPT_PASS_VECTOR);
    rd(LPT_OFS_LOCAL_STAT, 32'h1);
    pins(2'b00, 8'h01);
    pins(2'b10, 8'h01);
    pins(2'b00, 8'h01);
    wr(LPT_OFS_LOCAL_CFG, 32'h0000019c);
    pins(2'b10, 8'h02);
    rd(LPT_OFS_LOCAL_STAT, 32'h2);
    pins(2'b00, 8'h02);
    pins(2'b11, 8'h03);
    pins(2'b01, 8'h03);
    wr(LPT_OFS_LOCAL_CFG, 32'h0000019d);
    pins(2'b01, 8'h03);
    pins(2'b00, 8'h04);
    // dummy descriptor sits in host memory; this is the go write after it
    wr(LPT_OFS_START_XFER, 32'h1);
    rd(LPT_OFS_START_XFER, 32'h1);
    // both dma events at once, sink stalled so the order shows
    stall = 1'b1;
    dma_evt_tx = 2'b01;
    dma_evt_rx = 2'b10;
    idle(1);
    dma_evt_tx = 2'b00;
    dma_evt_rx = 2'b00;
    idle(6);
    stall = 1'b0;
    expect_vec(8'h05, TB, 32'h2);
    expect_vec(8'h06, RB, 32'h1);
    wr(LPT_OFS_GLOBAL_CFG, 32'h1);
    wr(LPT_OFS_LOCAL_CFG, 32'h00000db8);
    idle(2);
    chk("line enables", 32'h2, dma_line_en[1:0]);
    wr(LPT_OFS_LOCAL_CFG, 32'h000005b8);
    idle(2);
    chk("line enables", 32'h1, dma_line_en[1:0]);
    wr(LPT_OFS_LOCAL_CFG, 32'h000001f8);
    idle(2);
    chk("line enables", 32'hf, dma_line_en);
    wr(LPT_OFS_LOCAL_CFG, 32'h000001b0);
    pins(2'b01, 8'h06);
    pins(2'b00, 8'h06);
    wr(LPT_OFS_LOCAL_CFG, 32'h000001b8);
    pins(2'b01, 8'h07);
    expect_vec(8'h07, PB, LPT_PASS_VECTOR);
    final_report();
  end
endmodule : test_lpt_irq_pass
bind lpt_irq_pass lpt_irq_pass_checker i_chk (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .periph_irq_in_one(periph_irq_in_one), .periph_irq_in_two(periph_irq_in_two),
  .vec_valid(vec_valid), .vec_ready(vec_ready), .vec_addr(vec_addr), .vec_data(vec_data),
  .kick_chan(kick_chan), .ext_bus_ctrl_enable(ext_bus_ctrl_enable));
